// ==== thermal_pkg.sv ====
`default_nettype none
package thermal_pkg;

  // ==========================================================
  // data widths
  localparam int TEMP_W = 13;
  localparam int LIM_W = 9;
  localparam int ADDR_W = 8;

  // ==========================================================
  // register indices and byte addresses
  localparam logic [ADDR_W-1:0] IDX_MEASURED = 8'h00;
  localparam logic [ADDR_W-1:0] IDX_SETTINGS = 8'h01;
  localparam logic [ADDR_W-1:0] IDX_RELEASE = 8'h02;
  localparam logic [ADDR_W-1:0] IDX_UPPER = 8'h03;
  localparam logic [ADDR_W-1:0] IDX_IDENT = 8'h05;
  localparam logic [ADDR_W-1:0] ADDR_MEASURED = IDX_MEASURED << 2;
  localparam logic [ADDR_W-1:0] ADDR_SETTINGS = IDX_SETTINGS << 2;
  localparam logic [ADDR_W-1:0] ADDR_RELEASE = IDX_RELEASE << 2;
  localparam logic [ADDR_W-1:0] ADDR_UPPER = IDX_UPPER << 2;
  localparam logic [ADDR_W-1:0] ADDR_IDENT = IDX_IDENT << 2;

  // ==========================================================
  // settings field positions
  localparam int SHUTDOWN_BIT = 0;
  localparam int ALARM_MODE_BIT = 1;
  localparam int ALARM_POL_BIT = 2;
  localparam int FAULT_LSB = 3;
  localparam int RATE_LSB = 5;
  localparam int SETTINGS_W = 8;
  // measured register status bits
  localparam int VALID_BIT = 16;
  localparam int BUSY_BIT = 17;

  // ==========================================================
  // reset values (limits in 0.5 degree steps)
  localparam logic [SETTINGS_W-1:0] SETTINGS_RST = 8'h00;
  localparam logic [LIM_W-1:0] UPPER_RST = 9'h0A0;
  localparam logic [LIM_W-1:0] RELEASE_RST = 9'h096;
  localparam logic [TEMP_W-1:0] MEASURED_RST = 13'h0;
  // identity value is arbitrary
  localparam logic [7:0] IDENT_DEFAULT = 8'h5A;

  // ==========================================================
  // timing
  localparam longint CLK_HZ = 20_000_000;
  localparam longint CONV_TIME_US = 33_000;
  localparam longint PERIOD_R10_US = 100_000;
  localparam longint PERIOD_R0125_US = 8_000_000;
  localparam longint PERIOD_R1_US = 1_000_000;
  localparam longint PERIOD_R30_US = 33_333;
  localparam int CONV_CYC = int'(CONV_TIME_US * CLK_HZ / 1_000_000);
  localparam int PER10_CYC = int'(PERIOD_R10_US * CLK_HZ / 1_000_000);
  localparam int PER0125_CYC = int'(PERIOD_R0125_US * CLK_HZ / 1_000_000);
  localparam int PER1_CYC = int'(PERIOD_R1_US * CLK_HZ / 1_000_000);
  localparam int PER30_CYC = int'(PERIOD_R30_US * CLK_HZ / 1_000_000);

  // ==========================================================
  // encodings
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RATE_10 = 2'h0;
  localparam logic [1:0] RATE_0125 = 2'h1;
  localparam logic [1:0] RATE_1 = 2'h2;
  localparam logic [1:0] RATE_30 = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_WAIT = 3'b100
  } seq_state_t;

endpackage
`default_nettype wire

// ==== thermal_watchdog.sv ====
`default_nettype none
// Functional notes
// - results stored as 13-bit two's complement, 0.03125 degree per step
// - reads allowed any time and never disturb a running conversion
// - normal mode converts periodically, default 100 ms; result updates at end only
// - shutdown stops conversions, keeps last result, registers stay accessible
// - shutdown bit 1 enters shutdown, 0 returns to normal mode
// - conversion starts at once after reset and on leaving shutdown
// - 9 upper result bits compared with 9-bit signed limits after each conversion
// - rate choices 0.125, 1, 10, 30 per second, default 10
// - rate field bits 6:5; 00=10, 01=0.125, 10=1, 11=30 per second
// - comparator mode: active above upper limit, inactive below release limit
// - comparator mode: reads and shutdown leave the alarm unchanged
// - interrupt mode first fires above upper limit, held until any read of a mapped register
// - after first clear, interrupt fires below release limit, held until read
// - interrupt mode: entering shutdown clears the alarm
// - alarm activates only after programmed consecutive trips at conversion ends
// - fault field 00/01/10/11 means 1/2/4/6 consecutive trips, default 1
// - fault field bits 4:3, polarity bit 2
// - polarity 1 active high, 0 active low, default 0
// - mode bit 1 interrupt, 0 comparator, default comparator
// - reset: normal, comparator, limits 80 and 75 degrees, active low
// - measured value valid only after first conversion, about 33 ms
module thermal_watchdog #(
  parameter int CONV_CYCLES = thermal_pkg::CONV_CYC,
  parameter int PERIOD_10 = thermal_pkg::PER10_CYC,
  parameter int PERIOD_0125 = thermal_pkg::PER0125_CYC,
  parameter int PERIOD_1 = thermal_pkg::PER1_CYC,
  parameter int PERIOD_30 = thermal_pkg::PER30_CYC,
  parameter logic [7:0] IDENT_CODE = thermal_pkg::IDENT_DEFAULT
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [thermal_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [thermal_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [thermal_pkg::TEMP_W-1:0] sensor_temp,
  output logic alarm_pin_o,
  output logic alarm_pin_oe
);
  import thermal_pkg::*;

  // ==========================================================
  // sensor input synchroniser
  logic [TEMP_W-1:0] temp_meta_q;
  logic [TEMP_W-1:0] temp_sync_q;

  always_ff @(posedge aclk) begin
    temp_meta_q <= sensor_temp;
    temp_sync_q <= temp_meta_q;
  end

  // ==========================================================
  // register state
  logic [SETTINGS_W-1:0] settings_q;
  logic [LIM_W-1:0] upper_q;
  logic [LIM_W-1:0] release_q;
  logic [TEMP_W-1:0] measured_q;
  logic valid_q;

  // ==========================================================
  // write channel
  logic aw_got_q;
  logic w_got_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic aw_hs;
  logic w_hs;
  logic wr_fire;
  logic [31:0] wmask;
  logic wr_settings;
  logic wr_upper;
  logic wr_release;
  logic wr_known;
  logic [31:0] new_settings;
  logic [31:0] new_upper;
  logic [31:0] new_release;

  // ==========================================================
  // write handshake readies

  assign s_axi_awready = !aw_got_q && !bvalid_q;
  assign s_axi_wready = !w_got_q && !bvalid_q;
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign wr_fire = aw_got_q && w_got_q && !bvalid_q;
  assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign wr_settings = wr_fire && (awaddr_q == ADDR_SETTINGS);
  assign wr_upper = wr_fire && (awaddr_q == ADDR_UPPER);
  assign wr_release = wr_fire && (awaddr_q == ADDR_RELEASE);
  assign wr_known = (awaddr_q == ADDR_SETTINGS) || (awaddr_q == ADDR_UPPER) ||
                    (awaddr_q == ADDR_RELEASE) || (awaddr_q == ADDR_MEASURED) ||
                    (awaddr_q == ADDR_IDENT);
  assign new_settings = ({24'h000000, settings_q} & ~wmask) | (wdata_q & wmask);
  assign new_upper = ({23'h0, upper_q} & ~wmask) | (wdata_q & wmask);
  assign new_release = ({23'h0, release_q} & ~wmask) | (wdata_q & wmask);
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (aw_hs) begin
        aw_got_q <= 1'b1;
        awaddr_q <= {s_axi_awaddr[ADDR_W-1:2], 2'b00};
      end
      if (w_hs) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // read channel
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic ar_hs;
  logic rd_known;
  logic reg_read;
  logic [ADDR_W-1:0] raddr;
  logic [31:0] rd_mux;
  logic conv_busy;

  // ==========================================================
  // read handshake and address decode

  assign s_axi_arready = !rvalid_q;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign raddr = {s_axi_araddr[ADDR_W-1:2], 2'b00};
  assign rd_known = (raddr == ADDR_SETTINGS) || (raddr == ADDR_UPPER) ||
                    (raddr == ADDR_RELEASE) || (raddr == ADDR_MEASURED) ||
                    (raddr == ADDR_IDENT);
  assign reg_read = ar_hs && rd_known;
  // reads only sample the stored result
  assign rd_mux = (raddr == ADDR_MEASURED) ?
                    {14'h0, conv_busy, valid_q, 3'h0, measured_q} :
                  (raddr == ADDR_SETTINGS) ? {24'h000000, settings_q} :
                  (raddr == ADDR_UPPER) ? {23'h0, upper_q} :
                  (raddr == ADDR_RELEASE) ? {23'h0, release_q} :
                  (raddr == ADDR_IDENT) ? {24'h000000, IDENT_CODE} : 32'h00000000;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ==========================================================
  // settings and limits
  logic shutdown;
  logic int_mode;
  logic pol_high;
  logic [1:0] fault_sel;
  logic [1:0] rate_sel;
  logic enter_shutdown;

  assign shutdown = settings_q[SHUTDOWN_BIT];
  assign int_mode = settings_q[ALARM_MODE_BIT];
  assign pol_high = settings_q[ALARM_POL_BIT];
  assign fault_sel = settings_q[FAULT_LSB +: 2];
  assign rate_sel = settings_q[RATE_LSB +: 2];
  assign enter_shutdown = wr_settings && new_settings[SHUTDOWN_BIT] && !shutdown;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settings_q <= SETTINGS_RST;
      upper_q <= UPPER_RST;
      release_q <= RELEASE_RST;
    end else begin
      if (wr_settings) begin
        settings_q <= new_settings[SETTINGS_W-1:0];
      end
      if (wr_upper) begin
        upper_q <= new_upper[LIM_W-1:0];
      end
      if (wr_release) begin
        release_q <= new_release[LIM_W-1:0];
      end
    end
  end

  // ==========================================================
  // conversion sequencer
  seq_state_t state_q;
  seq_state_t state_d;
  logic [31:0] conv_cnt_q;
  logic [31:0] per_cnt_q;
  logic [31:0] period_cyc;
  logic conv_done;
  logic period_done;

  assign period_cyc = (rate_sel == RATE_0125) ? 32'(PERIOD_0125) :
                      (rate_sel == RATE_1) ? 32'(PERIOD_1) :
                      (rate_sel == RATE_30) ? 32'(PERIOD_30) : 32'(PERIOD_10);
  assign conv_done = (state_q == ST_CONV) && (conv_cnt_q == 32'(CONV_CYCLES - 1));
  assign period_done = (per_cnt_q >= period_cyc - 32'h00000001);
  assign conv_busy = (state_q == ST_CONV);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (!shutdown) begin
          state_d = ST_CONV;
        end
      end
      ST_CONV: begin
        if (shutdown) begin
          state_d = ST_IDLE;
        end else if (conv_done) begin
          state_d = period_done ? ST_CONV : ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (shutdown) begin
          state_d = ST_IDLE;
        end else if (period_done) begin
          state_d = ST_CONV;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_CONV;
      conv_cnt_q <= 32'h00000000;
      per_cnt_q <= 32'h00000000;
    end else begin
      state_q <= state_d;
      if (state_d == ST_CONV && state_q != ST_CONV || conv_done && state_d == ST_CONV) begin
        conv_cnt_q <= 32'h00000000;
        per_cnt_q <= 32'h00000000;
      end else begin
        conv_cnt_q <= (state_q == ST_CONV) ? conv_cnt_q + 32'h00000001 : conv_cnt_q;
        per_cnt_q <= per_cnt_q + 32'h00000001;
      end
    end
  end

  // ==========================================================
  // result capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      measured_q <= MEASURED_RST;
      valid_q <= 1'b0;
    end else if (conv_done && !shutdown) begin
      measured_q <= temp_sync_q;
      valid_q <= 1'b1;
    end
  end

  // ==========================================================
  // trip detection and fault counting
  logic signed [LIM_W-1:0] temp9;
  logic above_upper;
  logic below_release;
  logic active_q;
  logic look_high_q;
  logic trip;
  logic [2:0] fault_cnt_q;
  logic [2:0] fault_need;
  logic fault_met;
  logic fire;
  logic int_clear;

  // ==========================================================
  // limit comparison

  assign temp9 = temp_sync_q[TEMP_W-1 -: LIM_W];
  assign above_upper = temp9 > $signed(upper_q);
  assign below_release = temp9 < $signed(release_q);
  assign fault_need = (fault_sel == 2'h0) ? 3'h1 :
                      (fault_sel == 2'h1) ? 3'h2 :
                      (fault_sel == 2'h2) ? 3'h4 : 3'h6;
  // trip target per mode
  assign trip = int_mode ? (!active_q && (look_high_q ? above_upper : below_release)) :
                           (!active_q && above_upper);
  assign fault_met = (fault_cnt_q + 3'h1) >= fault_need;
  assign fire = conv_done && !shutdown && trip && fault_met;
  assign int_clear = int_mode && (reg_read || enter_shutdown);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_cnt_q <= 3'h0;
    end else if (conv_done && !shutdown) begin
      fault_cnt_q <= (trip && !fault_met) ? fault_cnt_q + 3'h1 : 3'h0;
    end
  end

  // ==========================================================
  // alarm state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_q <= 1'b0;
      look_high_q <= 1'b1;
    end else if (fire) begin
      active_q <= 1'b1;
    end else if (!int_mode && conv_done && !shutdown && active_q && below_release) begin
      active_q <= 1'b0;
    end else if (int_clear && active_q) begin
      active_q <= 1'b0;
      look_high_q <= 1'b0;
    end
  end

  // ==========================================================
  // open-drain alarm pin
  logic pin_low_d;
  logic pin_oe_q;

  assign pin_low_d = (active_q != pol_high);
  assign alarm_pin_o = 1'b0;
  assign alarm_pin_oe = pin_oe_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_oe_q <= 1'b0;
    end else begin
      pin_oe_q <= pin_low_d;
    end
  end

endmodule
`default_nettype wire

// ==== thermal_watchdog_monitor.sv ====
`default_nettype none
// ====================
// bus handshake and alarm pin checks
module thermal_watchdog_monitor
  import thermal_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic alarm_pin_o,
  input wire logic alarm_pin_oe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire ar_take = s_axi_arvalid && s_axi_arready;
  a_read_answer: assert property (ar_take |=> s_axi_rvalid)
    else $error("read not answered");
  a_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not released");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write not answered");
  a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_settings_width: assert property (
    ar_take && s_axi_araddr == ADDR_SETTINGS |=> s_axi_rdata[31:8] == 24'h0 &&
    s_axi_rresp == RESP_OKAY)
    else $error("settings read wider than eight bits");
  a_unmapped_error: assert property (
    ar_take && s_axi_araddr == 8'h10 |=> s_axi_rresp == RESP_SLVERR)
    else $error("reserved read not refused");
  a_open_drain: assert property (alarm_pin_o == 1'b0)
    else $error("alarm pin driven high");
  a_reset_inactive: assert property ($rose(aresetn) |-> ##2 !alarm_pin_oe)
    else $error("alarm active after reset");
endmodule
`default_nettype wire

// ==== thermal_sensor_model.sv ====
`default_nettype none
// ====================
// far side: temperature source and pulled-up alarm line
module thermal_sensor_model (
  input wire logic aclk,
  input wire logic [thermal_pkg::TEMP_W-1:0] temp_set,
  output logic [thermal_pkg::TEMP_W-1:0] sensor_temp,
  input wire logic alarm_pin_o,
  input wire logic alarm_pin_oe,
  output logic alarm_level
);
  always @(posedge aclk) sensor_temp <= temp_set;
  assign alarm_level = alarm_pin_oe ? alarm_pin_o : 1'b1;
endmodule
`default_nettype wire

// ==== test_thermal_watchdog.sv ====
`default_nettype none
module test_thermal_watchdog;
  timeunit 1ns;
  timeprecision 1ns;
  import thermal_pkg::*;
  // ====================
  // stimulus and design
  localparam int PER[4] = '{50, 400, 100, 30};
  localparam int NEED[4] = '{1, 2, 4, 6};
  localparam logic [7:0] IDC = 8'h3C; // arbitrary identity value
  localparam logic [12:0] COLD = 13'h0050, MID = 13'h0090, EQ = 13'h0100, HOT = 13'h0110;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, d, m;
  logic [12:0] temp_set = 13'h1F37, sensor_temp;
  logic awready, wready, bvalid, arready, rvalid, alarm_pin_o, alarm_pin_oe, alarm_level;
  logic [1:0] bresp, rresp;
  wire [31:0] d_bus;
  int fail_count = 0, num_checks = 0, cyc = 0, n, t0, c;
  always #25 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;
  thermal_watchdog #(.CONV_CYCLES(20), .PERIOD_10(PER[0]), .PERIOD_0125(PER[1]),
    .PERIOD_1(PER[2]), .PERIOD_30(PER[3]), .IDENT_CODE(IDC)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(d_bus), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sensor_temp(sensor_temp), .alarm_pin_o(alarm_pin_o), .alarm_pin_oe(alarm_pin_oe));
  thermal_sensor_model far (.aclk(aclk), .temp_set(temp_set), .sensor_temp(sensor_temp),
    .alarm_pin_o(alarm_pin_o), .alarm_pin_oe(alarm_pin_oe), .alarm_level(alarm_level));
  // ====================
  // tasks
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic hang(input string nm);
    fail_count++;
    $display("ERROR %s expected answer seen timeout", nm);
    conclude();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (k == 50) hang("bresp");
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (k == 50) hang("rresp");
    d = d_bus;
    rready <= 1'b0;
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask
  task automatic busy(input logic v);
    int k;
    for (k = 0; k < 300; k++) begin
      rd(ADDR_MEASURED, RESP_OKAY);
      if (d[BUSY_BIT] === v) break;
    end
    if (k == 300) hang("busy");
  endtask
  task automatic step(input logic [12:0] t);
    @(posedge aclk);
    temp_set <= t;
    busy(1'b0);
    busy(1'b1);
    busy(1'b0);
    repeat (3) @(posedge aclk);
  endtask
  task automatic wait_lvl(input logic v);
    int k;
    for (k = 0; k < 1000; k++) begin
      @(posedge aclk);
      if (alarm_level === v) break;
    end
    if (k == 1000) hang("alarm_level");
  endtask
  // ====================
  // tests
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_MEASURED, RESP_OKAY);
    chk("valid", 32'h0, {31'h0, d[VALID_BIT]});
    rd(ADDR_SETTINGS, RESP_OKAY);
    chk("settings", 32'h0, d);
    rd(ADDR_UPPER, RESP_OKAY);
    chk("upper", 32'hA0, d);
    rd(ADDR_RELEASE, RESP_OKAY);
    chk("release", 32'h96, d);
    rd(ADDR_IDENT, RESP_OKAY);
    chk("ident", {24'h0, IDC}, d);
    rd(8'h10, RESP_SLVERR);
    wr(8'h10, 32'hFF, RESP_SLVERR);
    chk("alarm_level", 32'h1, {31'h0, alarm_level});
    step(13'h1F37);
    rd(ADDR_MEASURED, RESP_OKAY);
    chk("measured", 32'h0001_1F37, d);
    $display("test reset and measure done");
    for (c = 0; c < 4; c++) begin
      wr(ADDR_SETTINGS, {25'h0, c[1:0], 5'h0}, RESP_OKAY);
      step(13'h1F37);
      busy(1'b1);
      t0 = cyc;
      busy(1'b0);
      busy(1'b1);
      chk("period", 32'h1, {31'h0, (cyc - t0 >= PER[c] - 4) && (cyc - t0 <= PER[c] + 4)});
    end
    $display("test rates done");
    wr(ADDR_UPPER, 32'h10, RESP_OKAY);
    wr(ADDR_RELEASE, 32'h08, RESP_OKAY);
    for (c = 0; c < 4; c++) begin
      wr(ADDR_SETTINGS, {27'h0, c[1:0], 3'h0}, RESP_OKAY);
      step(COLD);
      chk("alarm_level", 32'h1, {31'h0, alarm_level});
      for (n = 1; n < 8; n++) begin
        step(HOT);
        if (alarm_level === 1'b0) break;
      end
      chk("fault_count", NEED[c], n);
    end
    wr(ADDR_SETTINGS, 32'h08, RESP_OKAY);
    step(COLD);
    step(HOT);
    step(EQ);
    step(HOT);
    chk("alarm_level", 32'h1, {31'h0, alarm_level});
    step(HOT);
    chk("alarm_level", 32'h0, {31'h0, alarm_level});
    rd(ADDR_SETTINGS, RESP_OKAY);
    wr(ADDR_SETTINGS, 32'h09, RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk("alarm_level", 32'h0, {31'h0, alarm_level});
    wr(ADDR_SETTINGS, 32'h08, RESP_OKAY);
    step(MID);
    chk("alarm_level", 32'h0, {31'h0, alarm_level});
    step(COLD);
    chk("alarm_level", 32'h1, {31'h0, alarm_level});
    wr(ADDR_SETTINGS, 32'h0C, RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk("alarm_level", 32'h0, {31'h0, alarm_level});
    step(HOT);
    step(HOT);
    chk("alarm_level", 32'h1, {31'h0, alarm_level});
    step(COLD);
    $display("test comparator done");
    wr(ADDR_SETTINGS, 32'h02, RESP_OKAY);
    @(posedge aclk);
    temp_set <= HOT;
    wait_lvl(1'b0);
    repeat (120) @(posedge aclk);
    chk("alarm_level", 32'h0, {31'h0, alarm_level});
    rd(ADDR_IDENT, RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk("alarm_level", 32'h1, {31'h0, alarm_level});
    repeat (120) @(posedge aclk);
    chk("alarm_level", 32'h1, {31'h0, alarm_level});
    temp_set <= COLD;
    wait_lvl(1'b0);
    wr(ADDR_SETTINGS, 32'h03, RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk("alarm_level", 32'h1, {31'h0, alarm_level});
    rd(ADDR_MEASURED, RESP_OKAY);
    m = d;
    temp_set <= MID;
    repeat (200) @(posedge aclk);
    rd(ADDR_MEASURED, RESP_OKAY);
    chk("measured", m, d);
    wr(ADDR_SETTINGS, 32'h02, RESP_OKAY);
    rd(ADDR_MEASURED, RESP_OKAY);
    chk("busy", 32'h1, {31'h0, d[BUSY_BIT]});
    $display("test interrupt and shutdown done");
    conclude();
  end
endmodule
bind thermal_watchdog thermal_watchdog_monitor mon (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .alarm_pin_o(alarm_pin_o), .alarm_pin_oe(alarm_pin_oe));
`default_nettype wire
